// File: rtl/drc_core.sv
// Run-command, monitor and alarm-history interpreter of a motor drive
`default_nettype none
module drc_core
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  cmd_valid,
	input  wire logic                  cmd_write,
	input  wire logic [7:0]            cmd_code,
	input  wire logic [15:0]           cmd_data,
	input  wire logic [17:0]           func_assign,
	input  wire logic [3:0]            ext_enable,
	input  wire logic                  option_fitted,
	input  wire logic [15:0]           option_input_terms,
	input  wire logic [15:0]           option_input_terms2,
	input  wire logic [15:0]           option_output_terms,
	input  wire logic                  large_rating_pin,
	input  wire logic [15:0]           mon_current,
	input  wire logic [15:0]           mon_power,
	input  wire logic                  fault_event,
	input  wire logic [7:0]            fault_code,
	output logic                       rsp_valid,
	output logic                       rsp_error,
	output logic      [15:0]           rsp_data,
	output logic                       run_forward,
	output logic                       run_reverse,
	output logic                       current_input_select,
	output logic                       low_speed_cmd,
	output logic                       mid_speed_cmd,
	output logic                       high_speed_cmd,
	output logic                       second_function_select,
	output logic                       output_inhibit,
	output logic                       inching_run,
	output logic                       auto_restart_select,
	output logic                       start_self_hold,
	output logic                       drive_reset
);
	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed
	{
		logic [49:0] sync1;
		logic [49:0] sync2;
		logic        large_rating;
		logic [15:0] run_word;
		logic [5:0]  func_out;
		logic        fwd;
		logic        rev;
		logic [2:0]  ext_out;
		logic        rst_pulse;
		logic        rsp_valid;
		logic        rsp_error;
		logic [15:0] rsp_data;
		logic [31:0] alarm_log;
	} drc_state_s;

	drc_state_s st;
	drc_state_s next_st;
	logic [15:0] scaled_current;
	logic [15:0] scaled_power;

	// Pin inputs gathered for the two-stage synchroniser
	logic [49:0] pin_bundle;
	assign pin_bundle = {large_rating_pin, option_fitted, option_output_terms,
		option_input_terms2, option_input_terms};

	////////////////////////////////////////////////////////////////////////////////
	// Capacity scaling of current and power
	drc_scale u_scale_cur
	(
		.large_rating (st.large_rating),
		.raw_value    (mon_current),
		.scaled_value (scaled_current)
	);
	drc_scale u_scale_pwr
	(
		.large_rating (st.large_rating),
		.raw_value    (mon_power),
		.scaled_value (scaled_power)
	);

	// Function slot lookup of the assignment map
	function automatic logic [2:0] slot_func(input logic [17:0] map, input int slot);
		slot_func = map[slot*3 +: 3];
	endfunction

	// Run-word bit position of an assignable slot
	function automatic int slot_pos(input int slot);
		slot_pos = int'(drc_pkg::ASSIGN_POS[slot*4 +: 4]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic [15:0] w;
		logic [15:0] mon;
		logic        known;
		logic        opt_ok;
		w = st.run_word;
		mon = drc_pkg::WORD_ZERO;
		known = 1'b1;
		opt_ok = st.sync2[48];
		next_st = st;
		next_st.sync1 = pin_bundle;
		next_st.sync2 = st.sync1;
		// Strap taken from the synchronised pin, after reset release
		next_st.large_rating = st.sync2[49];
		next_st.rsp_valid = 1'b0;
		next_st.rsp_error = 1'b0;
		next_st.rst_pulse = 1'b0;

		// Fault log: newest in entry 0, older ones shift down
		if (fault_event)
			next_st.alarm_log = {st.alarm_log[23:0], fault_code};

		if (cmd_valid)
		begin
			next_st.rsp_valid = 1'b1;
			if (cmd_write)
			begin
				unique case (cmd_code)
					drc_pkg::CODE_RUN_SHORT:
						w = {8'h00, cmd_data[7:0]};
					drc_pkg::CODE_RUN_WIDE:
						w = {4'h0, cmd_data[11:0]};
					drc_pkg::CODE_RESET:
						next_st.rst_pulse = 1'b1;
					default:
						known = 1'b0;
				endcase
			end
			else
			begin
				// Monitor items and alarm history
				if (cmd_code == drc_pkg::MON_CURRENT)
					mon = scaled_current;
				else if (cmd_code == drc_pkg::MON_POWER)
					mon = scaled_power;
				else if (cmd_code == drc_pkg::MON_OPT_IN1)
					mon = opt_ok ? st.sync2[15:0] : drc_pkg::WORD_ZERO;
				else if (cmd_code == drc_pkg::MON_OPT_IN2)
					mon = opt_ok ? st.sync2[31:16] : drc_pkg::WORD_ZERO;
				else if (cmd_code == drc_pkg::MON_OPT_OUT)
					mon = opt_ok ? st.sync2[47:32] : drc_pkg::WORD_ZERO;
				else if (cmd_code >= drc_pkg::CODE_ALARM0 && cmd_code <= drc_pkg::CODE_ALARM3)
					mon = {8'h00, st.alarm_log[8*(cmd_code[1:0]) +: 8]};
				else
					known = 1'b0;
			end
			next_st.rsp_error = ~known;
			next_st.rsp_data = mon;
		end
		next_st.run_word = w;

		// Direction: both set is treated as stop, zero word stops
		next_st.fwd = w[drc_pkg::BIT_FWD] & ~w[drc_pkg::BIT_REV];
		next_st.rev = w[drc_pkg::BIT_REV] & ~w[drc_pkg::BIT_FWD];

		// Route each assignable bit to the function its setting names
		next_st.func_out = 6'h00;
		for (int s = 0; s < drc_pkg::N_ASSIGN; s++)
		begin
			if (int'(slot_func(func_assign, s)) < drc_pkg::N_ASSIGN)
				next_st.func_out[slot_func(func_assign, s)] =
					next_st.func_out[slot_func(func_assign, s)] | w[slot_pos(s)];
		end

		// Extended bits act only where their assignment enables them
		next_st.ext_out = w[drc_pkg::BIT_EXT_LO +: 3] & ext_enable[2:0];
		// Enabled fault-reset bit also resets, as a single pulse on its rise
		if (ext_enable[3] & w[drc_pkg::BIT_FAULT_RST] & ~st.run_word[drc_pkg::BIT_FAULT_RST])
			next_st.rst_pulse = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs straight from state
	assign rsp_valid              = st.rsp_valid;
	assign rsp_error              = st.rsp_error;
	assign rsp_data               = st.rsp_data;
	assign run_forward            = st.fwd;
	assign run_reverse            = st.rev;
	assign current_input_select   = st.func_out[drc_pkg::FN_CURRENT_SEL];
	assign low_speed_cmd          = st.func_out[drc_pkg::FN_LOW_SPEED];
	assign mid_speed_cmd          = st.func_out[drc_pkg::FN_MID_SPEED];
	assign high_speed_cmd         = st.func_out[drc_pkg::FN_HIGH_SPEED];
	assign second_function_select = st.func_out[drc_pkg::FN_SECOND_FN];
	assign output_inhibit         = st.func_out[drc_pkg::FN_OUT_INHIBIT];
	assign inching_run            = st.ext_out[0];
	assign auto_restart_select    = st.ext_out[1];
	assign start_self_hold        = st.ext_out[2];
	assign drive_reset            = st.rst_pulse;
endmodule
`default_nettype wire

// File: rtl/drc_pkg.sv
// Package: instruction codes, run-word field positions, function codes, monitor codes
`default_nettype none
package drc_pkg;
	// Instruction codes of the serial command vocabulary
	localparam logic [7:0] CODE_RUN_SHORT = 8'hFA;
	localparam logic [7:0] CODE_RUN_WIDE  = 8'hF9;
	localparam logic [7:0] CODE_RESET     = 8'hFD;
	localparam logic [7:0] CODE_ALARM0    = 8'h74;
	localparam logic [7:0] CODE_ALARM3    = 8'h77;
	// Monitor selection codes
	localparam logic [7:0] MON_CURRENT  = 8'h02;
	localparam logic [7:0] MON_POWER    = 8'h22;
	localparam logic [7:0] MON_OPT_IN1  = 8'h3A;
	localparam logic [7:0] MON_OPT_IN2  = 8'h3B;
	localparam logic [7:0] MON_OPT_OUT  = 8'h3C;
	// Run-word bit positions
	localparam int BIT_FWD        = 1;
	localparam int BIT_REV        = 2;
	localparam int BIT_EXT_LO     = 8;
	localparam int BIT_FAULT_RST  = 11;
	// Assignable bits of the run word, in order of function slot
	localparam int N_ASSIGN = 6;
	localparam logic [N_ASSIGN*4-1:0] ASSIGN_POS = {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h0};
	// Input functions that an assignable bit may carry
	typedef enum logic [2:0]
	{
		FN_CURRENT_SEL = 3'b000,
		FN_LOW_SPEED   = 3'b001,
		FN_MID_SPEED   = 3'b010,
		FN_HIGH_SPEED  = 3'b011,
		FN_SECOND_FN   = 3'b100,
		FN_OUT_INHIBIT = 3'b101
	} drc_func_e;
	// Power-on assignment: slot i carries function i
	localparam logic [N_ASSIGN*3-1:0] FUNC_DEFAULT = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
	// Fault codes, alarm-log depth, monitor scale divisor and zero word
	localparam logic [7:0] FAULT_NONE      = 8'h00;
	localparam logic [7:0] FAULT_OC_ACCEL  = 8'h10;
	localparam int         ALARM_DEPTH     = 4;
	localparam logic [7:0] SCALE_DIVISOR   = 8'h0A;
	localparam logic [15:0] WORD_ZERO      = 16'h0000;
endpackage
`default_nettype wire

// File: rtl/drc_scale.sv
// Capacity-dependent rescaling of current and power monitor values
`default_nettype none
module drc_scale
(
	input  wire logic        large_rating,
	input  wire logic [15:0] raw_value,
	output logic      [15:0] scaled_value
);
	// Raw value counts the finer unit; large ratings report the coarser one
	always_comb
	begin
		if (large_rating)
			scaled_value = raw_value / 16'(drc_pkg::SCALE_DIVISOR);
		else
			scaled_value = raw_value;
	end
endmodule
`default_nettype wire

// File: tb/drc_core_chk.sv
// Checker of run-word, reset and option-monitor behaviour at the core's ports
`default_nettype none
module drc_core_chk
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_data,
	input wire logic [3:0]  ext_enable,
	input wire logic        option_fitted,
	input wire logic [15:0] rsp_data,
	input wire logic        run_forward,
	input wire logic        run_reverse,
	input wire logic        inching_run,
	input wire logic        drive_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Write decodes; shared so every run-word property sees the same request
	wire logic ws = cmd_valid && cmd_write && cmd_code == drc_pkg::CODE_RUN_SHORT;
	wire logic ww = cmd_valid && cmd_write && cmd_code == drc_pkg::CODE_RUN_WIDE;
	chk_fwd_short: assert property (ws && cmd_data[7:0] == 8'h02
		|=> run_forward && !run_reverse) else $error("forward word not obeyed");
	chk_stop_zero: assert property (ws && cmd_data[7:0] == 8'h00
		|=> !run_forward && !run_reverse) else $error("zero word left rotation on");
	chk_both_stop: assert property ((ws || ww) && cmd_data[2:1] == 2'b11
		|=> !run_forward && !run_reverse) else $error("both directions not a stop");
	chk_reset_code: assert property (cmd_valid && cmd_write
		&& cmd_code == drc_pkg::CODE_RESET |=> drive_reset) else $error("no reset pulse");
	chk_ext_ignored: assert property (ww && !ext_enable[0]
		|=> !inching_run) else $error("disabled inching bit acted");
	chk_ext_enabled: assert property (ww && ext_enable[0] && cmd_data[8]
		|=> inching_run) else $error("enabled inching bit ignored");
	chk_short_clears: assert property (ws |=> !inching_run)
		else $error("short word kept extended bit");
	chk_opt_unfitted: assert property ((!option_fitted)[*4] ##0 (cmd_valid
		&& !cmd_write && cmd_code == drc_pkg::MON_OPT_IN1) |=> rsp_data == 16'h0000)
		else $error("unfitted option read nonzero");
endmodule
bind drc_core drc_core_chk u_chk
(
	.clk           (clk),
	.reset         (reset),
	.cmd_valid     (cmd_valid),
	.cmd_write     (cmd_write),
	.cmd_code      (cmd_code),
	.cmd_data      (cmd_data),
	.ext_enable    (ext_enable),
	.option_fitted (option_fitted),
	.rsp_data      (rsp_data),
	.run_forward   (run_forward),
	.run_reverse   (run_reverse),
	.inching_run   (inching_run),
	.drive_reset   (drive_reset)
);
`default_nettype wire

// File: tb/drc_host.sv
// Host master model issuing instruction requests and collecting answers
`default_nettype none
module drc_host
(
	input  wire logic        clk,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [15:0]      cmd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_data  = 16'h0000;
	end
	// One request held for its taking edge; idle code and data lines show the inverse so a stale
	// code can never pass for a fresh one. Run, stop and reset go by their codes.
	task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
		input int gap, output logic ok, output logic [15:0] rd);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code  = code;
		cmd_data  = data;
		@(posedge clk);
		#1;
		ok = rsp_valid;
		rd = rsp_data;
		cmd_valid = 1'b0;
		cmd_code  = ~code;
		cmd_data  = ~data;
	endtask
endmodule
`default_nettype wire

// File: tb/test_drive_run_command_monitor_codes.sv
// Self-checking bench of the run-command and monitor interpreter
`default_nettype none
module test_drive_run_command_monitor_codes;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset = 1'b1, cmd_valid, cmd_write, option_fitted = 1'b0, ok;
	logic large_rating_pin = 1'b0, fault_event = 1'b0, rsp_valid, rsp_error;
	logic run_forward, run_reverse, current_input_select, low_speed_cmd, mid_speed_cmd;
	logic high_speed_cmd, second_function_select, output_inhibit, inching_run;
	logic auto_restart_select, start_self_hold, drive_reset;
	logic [7:0]  cmd_code, fault_code = 8'h00;
	logic [3:0]  ext_enable = 4'h0;
	logic [17:0] func_assign = drc_pkg::FUNC_DEFAULT;
	logic [15:0] cmd_data, rsp_data, rd, mon_current = 16'h04D2, mon_power = 16'h0064;
	logic [15:0] option_input_terms = 16'hA5C3, option_input_terms2 = 16'h1234;
	logic [15:0] option_output_terms = 16'h00F0;
	logic [15:0] sv [4] = '{16'h0002, 16'h0000, 16'h0006, 16'h0004};
	logic [15:0] se [4] = '{16'h0002, 16'h0000, 16'h0000, 16'h0004};
	int          n_mismatch = 0, n_tests = 0;
	drc_core DUT (.*);
	drc_host host (.*);
	always #20 clk = ~clk;
	// Outputs gathered in run-word bit order, fault-reset pulse at bit 11
	wire logic [15:0] runv = {4'h0, drive_reset, start_self_hold, auto_restart_select,
		inching_run,
		output_inhibit, second_function_select, high_speed_cmd, mid_speed_cmd,
		low_speed_cmd, run_reverse, run_forward, current_input_select};
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// The answer is due on the very next edge, so it is checked on every request
	task automatic req(input logic w, input logic [7:0] c, input logic [15:0] d, int g = 0);
		host.xfer(w, c, d, g, ok, rd);
		chk("answer", {15'h0000, ok}, 16'h0001);
	endtask
	task automatic rdc(input string nm, input logic [7:0] c, input logic [15:0] exp);
		req(1'b0, c, 16'h0000, 2);
		chk(nm, rd, exp);
		// Known codes never raise the error flag; it stands with the answer
		chk({nm, " err"}, {15'h0000, rsp_error}, 16'h0000);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		req(1'b1, drc_pkg::CODE_RUN_SHORT, 16'hFFF9);
		chk("run map", runv, 16'h00F9);
		foreach (sv[i])
		begin
			req(1'b1, drc_pkg::CODE_RUN_SHORT, sv[i]);
			chk("run short", runv, se[i]);
		end
		func_assign = 18'h36DB5;
		req(1'b1, drc_pkg::CODE_RUN_SHORT, 16'h0001);
		chk("remap", runv, 16'h0080);
		func_assign = drc_pkg::FUNC_DEFAULT;
		$display("test short words done");
		req(1'b1, drc_pkg::CODE_RUN_WIDE, 16'h0F02);
		chk("ext off", runv, 16'h0002);
		ext_enable = 4'hF;
		req(1'b1, drc_pkg::CODE_RUN_WIDE, 16'hF702);
		chk("ext on", runv, 16'h0702);
		req(1'b1, drc_pkg::CODE_RUN_WIDE, 16'h0800);
		chk("fault reset", runv, 16'h0800);
		req(1'b1, drc_pkg::CODE_RUN_SHORT, 16'h0000);
		chk("short clears", runv, 16'h0000);
		req(1'b1, drc_pkg::CODE_RESET, 16'h0000);
		chk("reset code", {15'h0000, drive_reset}, 16'h0001);
		// Unknown code is flagged and must leave the stopped run word alone
		req(1'b1, 8'h01, 16'h0002);
		chk("unknown err", {15'h0000, rsp_error}, 16'h0001);
		chk("unknown keep", runv, 16'h0000);
		$display("test wide words done");
		rdc("opt unfitted", drc_pkg::MON_OPT_IN1, 16'h0000);
		option_fitted = 1'b1;
		large_rating_pin = 1'b1;
		repeat (3) @(posedge clk);
		rdc("opt in1", drc_pkg::MON_OPT_IN1, 16'hA5C3);
		rdc("opt in2", drc_pkg::MON_OPT_IN2, 16'h1234);
		rdc("opt out", drc_pkg::MON_OPT_OUT, 16'h00F0);
		rdc("cur coarse", drc_pkg::MON_CURRENT, 16'h007B);
		rdc("pwr coarse", drc_pkg::MON_POWER, 16'h000A);
		large_rating_pin = 1'b0;
		repeat (3) @(posedge clk);
		rdc("cur fine", drc_pkg::MON_CURRENT, 16'h04D2);
		$display("test monitors done");
		rdc("alarm empty", drc_pkg::CODE_ALARM0, 16'h0000);
		for (int i = 1; i < 3; i++)
		begin
			@(posedge clk);
			#1;
			fault_event = 1'b1;
			fault_code = 8'(16 * i);
		end
		@(posedge clk);
		#1;
		fault_event = 1'b0;
		rdc("alarm 0", drc_pkg::CODE_ALARM0, 16'h0020);
		rdc("alarm 1", 8'h75, {8'h00, drc_pkg::FAULT_OC_ACCEL});
		rdc("alarm 2", 8'h76, 16'h0000);
		$display("test alarms done");
		final_report();
	end
endmodule
`default_nettype wire
